// ### rtl/dmie_pkg.sv
// Purpose: Shared constants, types and decode helpers for the data-move executor
// Assumes: 16-bit instruction words, 128 x 4 data memory, working registers at the bottom of memory
// Notes:   One machine cycle is MCYC_CLKS clocks of mclk_i
package dmie_pkg;

   // ==================================================================
   // Timing and sizes
   localparam int MCYC_CLKS = 4;
   localparam int PH_W = 3;
   localparam int ADDR_W = 7;
   localparam int NIB_W = 4;

   localparam logic [PH_W-1:0] PH_RD_DIR = 3'h0;
   localparam logic [PH_W-1:0] PH_CAP_DIR = 3'h1;
   localparam logic [PH_W-1:0] PH_EXEC = 3'h2;
   localparam logic [PH_W-1:0] PH_CAP_WR = 3'h3;
   localparam logic [PH_W-1:0] PH_RD_IND = 3'h4;
   localparam logic [PH_W-1:0] PH_WR_IND = 3'h6;
   localparam logic [PH_W-1:0] PH_END_ONE = 3'(1 * MCYC_CLKS - 1);
   localparam logic [PH_W-1:0] PH_END_TWO = 3'(2 * MCYC_CLKS - 1);

   // ==================================================================
   // Memory layout and reset values
   localparam logic [ADDR_W-1:0] WORK_REG_BASE = 7'h00;
   localparam logic [ADDR_W-1:0] PAGE_STRIDE = 7'h10;
   localparam logic [NIB_W-1:0] NIB_RST = 4'h0;
   localparam logic [7:0] HRC_RST = 8'h00;
   localparam logic [7:0] HRC_RSV_MASK = 8'hf7;

   // ==================================================================
   // Opcode patterns
   localparam logic [15:0] OPC_LD_TBL = 16'b0001_0101_0???_????;
   localparam logic [15:0] OPC_LD_TBH = 16'b0001_0101_1???_????;
   localparam logic [15:0] OPC_LD_WR = 16'b1110_1???_????_????;
   localparam logic [15:0] OPC_LD_WR_IND = 16'b1100_1???_????_????;
   localparam logic [15:0] OPC_ST_WR_IND = 16'b1101_1???_????_????;
   localparam logic [15:0] OPC_LD_PAGE = 16'b0101_1101_????_????;
   localparam logic [15:0] OPC_MV_CARRY = 16'b0101_1001_0???_????;
   localparam logic [15:0] OPC_MV_HRC_HI = 16'b0100_1001_1???_????;
   localparam logic [15:0] OPC_MV_HRC_LO = 16'b0100_1001_0???_????;

   // ==================================================================
   // Types
   typedef enum logic [3:0] {
      OP_NONE, OP_LD_TBL, OP_LD_TBH, OP_LD_WR, OP_LD_WR_IND, OP_ST_WR_IND,
      OP_LD_PAGE, OP_MV_CARRY, OP_MV_HRC_HI, OP_MV_HRC_LO
   } dmie_op_type;

   typedef struct packed {
      logic [4:0] prefix;
      logic [3:0] work_reg_select_field;
      logic [6:0] direct_mem_addr_field;
   } dmie_instr_type;

   typedef struct packed {
      logic ser_tx_done;
      logic ser_rx_done;
      logic timer_b_underflow;
      logic ext_int_fall;
      logic reserved;
      logic third_input_port_change;
      logic timer_a_underflow;
      logic divider_overflow;
   } dmie_wake_type;

   // ==================================================================
   // Helpers
   function automatic dmie_op_type dmie_decode(input logic [15:0] w);
      dmie_op_type op;
      op = OP_NONE;
      casez (w)
         OPC_LD_TBL: op = OP_LD_TBL;
         OPC_LD_TBH: op = OP_LD_TBH;
         OPC_LD_WR: op = OP_LD_WR;
         OPC_LD_WR_IND: op = OP_LD_WR_IND;
         OPC_ST_WR_IND: op = OP_ST_WR_IND;
         OPC_LD_PAGE: op = OP_LD_PAGE;
         OPC_MV_CARRY: op = OP_MV_CARRY;
         OPC_MV_HRC_HI: op = OP_MV_HRC_HI;
         OPC_MV_HRC_LO: op = OP_MV_HRC_LO;
         default: op = OP_NONE;
      endcase
      return op;
   endfunction

   function automatic logic [ADDR_W-1:0] dmie_ind_addr(input logic [3:0] page, input logic [3:0] nib);
      return 7'(page[2:0] * PAGE_STRIDE) + {3'h0, nib};
   endfunction

   function automatic logic [ADDR_W-1:0] dmie_wr_addr(input logic [3:0] sel);
      return WORK_REG_BASE + {3'h0, sel};
   endfunction

endpackage

// ### rtl/dmie_data_mem.sv
// Purpose: Single-port nibble data memory with registered read data
// Assumes: One access per clock; a write does not update the read register
// Notes:   Read data holds until the next read
`timescale 1ns/100ps
module dmie_data_mem #(
   parameter int AW = 7,
   parameter int DW = 4
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic en_i,
   input wire logic we_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [DW-1:0] wdata_i,
   output logic [DW-1:0] rdata_o
);
   logic [DW-1:0] mem_q [0:(1<<AW)-1];
   logic [DW-1:0] rdata_q;

   always_ff @(posedge mclk_i) begin
      if (en_i && we_i) begin
         mem_q[addr_i] <= wdata_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rdata_q <= '0;
      end else if (en_i && !we_i) begin
         rdata_q <= mem_q[addr_i];
      end
   end

   assign rdata_o = rdata_q;
endmodule

// ### rtl/dmie_exec.sv
// Purpose: Decode and execute the data-move instruction group of a 4-bit core
// Assumes: Instructions arrive with a valid/ready handshake, one at a time
// Notes:   Unknown opcodes are taken and retired after one machine cycle with no effect
// What this block does
// - Direct nibble loads timer B preload low
// - Direct nibble loads timer B preload high
// - Direct nibble loads selected working register
// - Paged indirect read into working register, two cycles
// - Working register stored to paged indirect address
// - Direct nibble loads the page register
// - Carry to bit0 of accumulator and memory
// - Upper release flags to accumulator and memory
// - Lower release flags moved, bit3 reserved zero
// - External interrupt release sets flag 4
// - Timer B underflow release sets flag 5
// - Serial receive release sets flag 6
// - Serial transmit release sets flag 7
// - Divider overflow release sets flag 0
// - Timer A underflow release sets flag 1
// - Third input port change sets flag 2
`timescale 1ns/100ps
module dmie_exec (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic instr_valid_i,
   input dmie_pkg::dmie_instr_type instr_i,
   output logic instr_ready_o,
   output logic done_o,
   input wire logic carry_flag_i,
   input wire logic hold_mode_i,
   input wire logic hold_enter_i,
   input dmie_pkg::dmie_wake_type wake_cause_i,
   output logic [3:0] timer_b_preload_low_o,
   output logic [3:0] timer_b_preload_high_o,
   output logic [3:0] page_register_o,
   output logic [3:0] accumulator_o,
   output logic zero_flag_o,
   output logic [7:0] hold_release_cause_flags_o
);
   import dmie_pkg::*;

   typedef enum logic {ST_IDLE, ST_EXEC} dmie_state_type;

   // ==================================================================
   // Sequencer
   dmie_state_type state_q, state_d;
   logic [PH_W-1:0] ph_q, ph_d;
   dmie_op_type op_q, op_d;
   dmie_instr_type ins_q, ins_d;
   logic ready_q, ready_d;
   logic done_q, done_d;
   logic accept;

   assign accept = (state_q == ST_IDLE) && instr_valid_i && ready_q;

   always_comb begin
      state_d = state_q;
      ph_d = ph_q;
      op_d = op_q;
      ins_d = ins_q;
      done_d = 1'b0;
      unique case (state_q)
         ST_IDLE: begin
            if (accept) begin
               state_d = ST_EXEC;
               ph_d = PH_RD_DIR;
               op_d = dmie_decode(instr_i);
               ins_d = instr_i;
            end
         end
         ST_EXEC: begin
            if (ph_q == (((op_q == OP_LD_WR_IND) || (op_q == OP_ST_WR_IND)) ? PH_END_TWO : PH_END_ONE)) begin
               state_d = ST_IDLE;
               ph_d = PH_RD_DIR;
               done_d = 1'b1;
            end else begin
               ph_d = ph_q + 3'h1;
            end
         end
      endcase
      ready_d = (state_d == ST_IDLE);
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state_q <= ST_IDLE;
         ph_q <= PH_RD_DIR;
         op_q <= OP_NONE;
         ins_q <= '0;
         ready_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         ph_q <= ph_d;
         op_q <= op_d;
         ins_q <= ins_d;
         ready_q <= ready_d;
         done_q <= done_d;
      end
   end

   // ==================================================================
   // Datapath and memory access
   logic [3:0] dir_q, dir_d;
   logic [3:0] wrv_q, wrv_d;
   logic [3:0] tbl_q, tbl_d;
   logic [3:0] tbh_q, tbh_d;
   logic [3:0] page_q, page_d;
   logic [3:0] acc_q, acc_d;
   logic zf_q, zf_d;
   logic mem_en, mem_we;
   logic [ADDR_W-1:0] mem_addr;
   logic [3:0] mem_wdata, mem_rdata;
   logic [7:0] hrc_q, hrc_d;

   // Value placed in both accumulator and memory by the accumulator moves
   function automatic logic [3:0] move_value(input dmie_op_type op, input logic cy, input logic [7:0] hrc);
      logic [3:0] v;
      v = 4'h0;
      if (op == OP_MV_CARRY) begin
         v = {3'h0, cy};
      end else if (op == OP_MV_HRC_HI) begin
         v = hrc[7:4];
      end else if (op == OP_MV_HRC_LO) begin
         v = {1'b0, hrc[2:0]};
      end
      return v;
   endfunction

   always_comb begin
      logic [3:0] mv;
      mv = move_value(op_q, carry_flag_i, hrc_q);
      dir_d = dir_q;
      wrv_d = wrv_q;
      tbl_d = tbl_q;
      tbh_d = tbh_q;
      page_d = page_q;
      acc_d = acc_q;
      zf_d = zf_q;
      mem_en = 1'b0;
      mem_we = 1'b0;
      mem_addr = ins_q.direct_mem_addr_field;
      mem_wdata = 4'h0;
      if (state_q == ST_EXEC) begin
         if (ph_q == PH_RD_DIR) begin
            mem_en = 1'b1;
         end
         if (ph_q == PH_CAP_DIR) begin
            dir_d = mem_rdata;
         end
         if (ph_q == PH_EXEC) begin
            unique case (op_q)
               OP_LD_TBL: tbl_d = dir_q;
               OP_LD_TBH: tbh_d = dir_q;
               OP_LD_PAGE: page_d = dir_q;
               OP_LD_WR: begin
                  mem_en = 1'b1;
                  mem_we = 1'b1;
                  mem_addr = dmie_wr_addr(ins_q.work_reg_select_field);
                  mem_wdata = dir_q;
               end
               OP_ST_WR_IND: begin
                  mem_en = 1'b1;
                  mem_addr = dmie_wr_addr(ins_q.work_reg_select_field);
               end
               OP_MV_CARRY, OP_MV_HRC_HI, OP_MV_HRC_LO: begin
                  mem_en = 1'b1;
                  mem_we = 1'b1;
                  mem_wdata = mv;
                  acc_d = mv;
                  zf_d = (mv == 4'h0);
               end
               OP_NONE, OP_LD_WR_IND: begin
               end
            endcase
         end
         if (ph_q == PH_CAP_WR) begin
            wrv_d = mem_rdata;
         end
         if ((ph_q == PH_RD_IND) && (op_q == OP_LD_WR_IND)) begin
            mem_en = 1'b1;
            mem_addr = dmie_ind_addr(page_q, dir_q);
         end
         if (ph_q == PH_WR_IND) begin
            if (op_q == OP_LD_WR_IND) begin
               mem_en = 1'b1;
               mem_we = 1'b1;
               mem_addr = dmie_wr_addr(ins_q.work_reg_select_field);
               mem_wdata = mem_rdata;
            end else if (op_q == OP_ST_WR_IND) begin
               mem_en = 1'b1;
               mem_we = 1'b1;
               mem_addr = dmie_ind_addr(page_q, dir_q);
               mem_wdata = wrv_q;
            end
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         dir_q <= NIB_RST;
         wrv_q <= NIB_RST;
         tbl_q <= NIB_RST;
         tbh_q <= NIB_RST;
         page_q <= NIB_RST;
         acc_q <= NIB_RST;
         zf_q <= 1'b0;
      end else begin
         dir_q <= dir_d;
         wrv_q <= wrv_d;
         tbl_q <= tbl_d;
         tbh_q <= tbh_d;
         page_q <= page_d;
         acc_q <= acc_d;
         zf_q <= zf_d;
      end
   end

   dmie_data_mem #(
      .AW(ADDR_W),
      .DW(NIB_W)
   ) u_mem (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .en_i(mem_en),
      .we_i(mem_we),
      .addr_i(mem_addr),
      .wdata_i(mem_wdata),
      .rdata_o(mem_rdata)
   );

   // ==================================================================
   // Hold release cause flags
   // Cleared on hold entry; a cause in the same cycle still sets its flag
   always_comb begin
      hrc_d = hrc_q;
      if (hold_enter_i) begin
         hrc_d = HRC_RST;
      end
      if (hold_mode_i) begin
         hrc_d = hrc_d | (wake_cause_i & HRC_RSV_MASK);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         hrc_q <= HRC_RST;
      end else begin
         hrc_q <= hrc_d;
      end
   end

   assign instr_ready_o = ready_q;
   assign done_o = done_q;
   assign timer_b_preload_low_o = tbl_q;
   assign timer_b_preload_high_o = tbh_q;
   assign page_register_o = page_q;
   assign accumulator_o = acc_q;
   assign zero_flag_o = zf_q;
   assign hold_release_cause_flags_o = hrc_q;

   // ==================================================================
   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   logic in_exec;
   assign in_exec = (state_q == ST_EXEC);

   sequence seq_one_mcyc;
      !done_q [*4] ##1 done_q;
   endsequence

   sequence seq_two_mcyc;
      !done_q [*8] ##1 done_q;
   endsequence

   chk_tbl_load: assert property ((in_exec && ph_q == PH_CAP_DIR && op_q == OP_LD_TBL) |->
      ##2 (tbl_q == $past(mem_rdata, 2)) ##1 done_q) else $error("preload low not loaded");
   chk_tbh_load: assert property ((in_exec && ph_q == PH_CAP_DIR && op_q == OP_LD_TBH) |->
      ##2 (tbh_q == $past(mem_rdata, 2)) ##1 done_q) else $error("preload high not loaded");
   chk_wr_direct: assert property ((accept && dmie_decode(instr_i) == OP_LD_WR) |->
      ##3 (mem_we && mem_addr == dmie_wr_addr($past(instr_i.work_reg_select_field, 3))
      && mem_wdata == $past(mem_rdata, 1)) ##2 done_q)
      else $error("direct working register load wrong");
   chk_one_time: assert property ((accept && !(dmie_decode(instr_i) inside {OP_LD_WR_IND, OP_ST_WR_IND})) |=>
      seq_one_mcyc) else $error("single machine cycle op mistimed");
   chk_st_time: assert property ((accept && dmie_decode(instr_i) == OP_ST_WR_IND) |=> seq_two_mcyc)
      else $error("indirect store not two machine cycles");
   chk_ind_load: assert property ((in_exec && ph_q == PH_CAP_DIR && op_q == OP_LD_WR_IND) |->
      ##3 (mem_en && !mem_we && mem_addr == dmie_ind_addr(page_q, $past(mem_rdata, 3)))
      ##2 (mem_we && mem_wdata == $past(mem_rdata, 1)) ##2 done_q) else $error("indirect load wrong");
   chk_ind_time: assert property ((accept && dmie_decode(instr_i) == OP_LD_WR_IND) |=> seq_two_mcyc)
      else $error("indirect load not two machine cycles");
   chk_ind_store: assert property ((in_exec && ph_q == PH_CAP_WR && op_q == OP_ST_WR_IND) |->
      ##3 (mem_we && mem_wdata == $past(mem_rdata, 3) && mem_addr == dmie_ind_addr(page_q, dir_q)))
      else $error("indirect store wrong");
   chk_page_load: assert property ((in_exec && ph_q == PH_CAP_DIR && op_q == OP_LD_PAGE) |->
      ##2 (page_q == $past(mem_rdata, 2))) else $error("page register not loaded");
   chk_carry_move: assert property ((in_exec && ph_q == PH_EXEC && op_q == OP_MV_CARRY) |=>
      (acc_q == {3'h0, $past(carry_flag_i)}) && (zf_q == !$past(carry_flag_i))) else $error("carry move wrong");
   chk_hrc_upper: assert property ((in_exec && ph_q == PH_EXEC && op_q == OP_MV_HRC_HI) |->
      mem_we && mem_wdata == hrc_q[7:4] ##1 acc_q == $past(hrc_q[7:4])) else $error("upper flag move wrong");
   chk_hrc_lower: assert property ((in_exec && ph_q == PH_EXEC && op_q == OP_MV_HRC_LO) |=>
      !acc_q[3] && acc_q[2:0] == $past(hrc_q[2:0])) else $error("lower flag move wrong");
   chk_rsv_zero: assert property (!hrc_q[3]) else $error("reserved flag set");
   chk_flag_int: assert property ((hold_mode_i && wake_cause_i.ext_int_fall) |=> hrc_q[4])
      else $error("flag 4 not set");
   chk_flag_tmb: assert property ((hold_mode_i && wake_cause_i.timer_b_underflow) |=> hrc_q[5])
      else $error("flag 5 not set");
   chk_flag_srx: assert property ((hold_mode_i && wake_cause_i.ser_rx_done) |=> hrc_q[6])
      else $error("flag 6 not set");
   chk_flag_stx: assert property ((hold_mode_i && wake_cause_i.ser_tx_done) |=> hrc_q[7])
      else $error("flag 7 not set");
   chk_flag_div: assert property ((hold_mode_i && wake_cause_i.divider_overflow) |=> hrc_q[0])
      else $error("flag 0 not set");
   chk_flag_tma: assert property ((hold_mode_i && wake_cause_i.timer_a_underflow) |=> hrc_q[1])
      else $error("flag 1 not set");
   chk_flag_port: assert property ((hold_mode_i && wake_cause_i.third_input_port_change) |=> hrc_q[2])
      else $error("flag 2 not set");
   chk_zero_flag: assert property ((in_exec && ph_q == PH_EXEC && op_q inside {OP_MV_CARRY, OP_MV_HRC_HI,
      OP_MV_HRC_LO}) |=> (zf_q == (acc_q == 4'h0))) else $error("zero flag mismatch");
endmodule

// ### verification/data_move_instr_exec_tb_top.sv
// Purpose: Self-checking bench for the data-move executor
// Assumes: Memory is filled through the release-flag moves before it is read
// Notes:   Memory contents are observed through timer B preload low loads
`timescale 1ns/100ps
module data_move_instr_exec_tb_top;
   import dmie_pkg::*;
   // ==================================================================
   // Clock, ports, model state
   logic mclk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic instr_valid_i = 1'b0;
   dmie_instr_type instr_i = '0;
   logic carry_flag_i = 1'b0;
   logic hold_mode_i = 1'b0;
   logic hold_enter_i = 1'b0;
   dmie_wake_type wake_cause_i = '0;
   logic instr_ready_o, done_o, zero_flag_o;
   logic [3:0] timer_b_preload_low_o, timer_b_preload_high_o, page_register_o, accumulator_o;
   logic [7:0] hold_release_cause_flags_o;
   int mismatches = 0;
   int comparisons = 0;
   int mem_m[128];
   int tbl_m = 0, tbh_m = 0, page_m = 0, accum_m = 0, zero_m = 0, flags_m = 0;
   logic [31:0] rnd = 32'h216a;
   logic [15:0] base_t[10] = '{16'h1500, 16'h1580, 16'he800, 16'hc800, 16'hd800,
                               16'h5d00, 16'h5900, 16'h4980, 16'h4900, 16'hf800};
   logic [15:0] mask_t[10] = '{16'h007f, 16'h007f, 16'h07ff, 16'h07ff, 16'h07ff,
                               16'h00ff, 16'h007f, 16'h007f, 16'h007f, 16'h07ff};

   always #12.5 mclk_i = ~mclk_i;

   dmie_exec i_dut (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
      .instr_ready_o(instr_ready_o), .done_o(done_o), .carry_flag_i(carry_flag_i),
      .hold_mode_i(hold_mode_i), .hold_enter_i(hold_enter_i), .wake_cause_i(wake_cause_i),
      .timer_b_preload_low_o(timer_b_preload_low_o), .timer_b_preload_high_o(timer_b_preload_high_o),
      .page_register_o(page_register_o), .accumulator_o(accumulator_o), .zero_flag_o(zero_flag_o),
      .hold_release_cause_flags_o(hold_release_cause_flags_o)
   );

   // ==================================================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return (x >> 1) ^ (x[0] ? 32'h80200003 : 32'h0);
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check_all();
      check({4'h0, timer_b_preload_low_o}, 8'(tbl_m));
      check({4'h0, timer_b_preload_high_o}, 8'(tbh_m));
      check({4'h0, page_register_o}, 8'(page_m));
      check({4'h0, accumulator_o}, 8'(accum_m));
      check({7'h0, zero_flag_o}, 8'(zero_m));
      check(hold_release_cause_flags_o, 8'(flags_m));
   endtask

   // Cause seen outside hold is ignored, clear with a same-cycle cause keeps it, then causes accumulate
   task automatic set_flags(input logic [7:0] v, input logic [7:0] v2);
      hold_mode_i = 1'b0;
      wake_cause_i = ~v;
      @(negedge mclk_i);
      check(hold_release_cause_flags_o, 8'(flags_m));
      hold_mode_i = 1'b1;
      hold_enter_i = 1'b1;
      wake_cause_i = v;
      @(negedge mclk_i);
      flags_m = v & 8'hf7;
      check(hold_release_cause_flags_o, 8'(flags_m));
      hold_enter_i = 1'b0;
      wake_cause_i = v2;
      @(negedge mclk_i);
      flags_m = flags_m | (v2 & 8'hf7);
      hold_mode_i = 1'b0;
      wake_cause_i = '0;
      check(hold_release_cause_flags_o, 8'(flags_m));
   endtask

   task automatic model(input int k, input logic [15:0] w, input logic c, output int ncyc);
      int d, s, ia;
      d = w[6:0];
      s = w[10:7];
      ia = (page_m % 8) * 16 + mem_m[d];
      ncyc = 5;
      case (k)
         0: tbl_m = mem_m[d];
         1: tbh_m = mem_m[d];
         2: mem_m[s] = mem_m[d];
         3: begin
            mem_m[s] = mem_m[ia];
            ncyc = 9;
         end
         4: begin
            mem_m[ia] = mem_m[s];
            ncyc = 9;
         end
         5: page_m = mem_m[d];
         6: accum_m = c;
         7: accum_m = flags_m / 16;
         8: accum_m = flags_m % 8;
         default: ;
      endcase
      if (k >= 6 && k <= 8) begin
         mem_m[d] = accum_m;
         zero_m = (accum_m == 0);
      end
   endtask

   // Offers one word at a falling edge and counts cycles from the taking edge to done
   task automatic exec(input int k, input logic [15:0] w, input logic c);
      int n, ncyc;
      model(k, w, c, ncyc);
      n = 0;
      while (instr_ready_o !== 1'b1 && n < 50) begin
         @(negedge mclk_i);
         n++;
      end
      check({7'h0, instr_ready_o}, 8'h1);
      instr_valid_i = 1'b1;
      instr_i = w;
      carry_flag_i = c;
      @(negedge mclk_i);
      instr_valid_i = 1'b0;
      instr_i = ~w;
      check({7'h0, instr_ready_o}, 8'h0);
      n = 1;
      while (done_o !== 1'b1 && n < 20) begin
         @(negedge mclk_i);
         n++;
      end
      check(8'(n), 8'(ncyc));
      check_all();
   endtask

   // ==================================================================
   // Main sequence
   initial begin
      int k;
      logic [15:0] w;
      repeat (16) @(negedge mclk_i);
      check({7'h0, instr_ready_o}, 8'h0);
      check_all();
      sys_rst_i = 1'b0;
      @(negedge mclk_i);
      for (int a = 0; a < 128; a++) begin
         rnd = lfsr(rnd);
         if (a < 4) begin
            set_flags(8'h00, 8'h00);
         end else begin
            set_flags(rnd[7:0], rnd[15:8]);
         end
         k = (a % 2 == 1) ? 7 : 8;
         exec(k, base_t[k] | 16'(a), rnd[16]);
      end
      for (int i = 0; i < 400; i++) begin
         rnd = lfsr(rnd);
         k = int'(rnd[7:0]) % 10;
         w = base_t[k] | (rnd[31:16] & mask_t[k]);
         if (i % 16 == 15) begin
            set_flags(rnd[15:8], rnd[23:16]);
         end
         exec(k, w, rnd[9]);
      end
      // Sweep every location back out through the preload low path
      for (int a = 0; a < 128; a++) begin
         exec(0, base_t[0] | 16'(a), 1'b0);
         check({4'h0, timer_b_preload_low_o}, 8'(mem_m[a]));
      end
      conclude();
   end

   initial begin
      #(25.0 * 20000);
      mismatches++;
      conclude();
   end
endmodule
